// [fbc_params.svh]
/*
  Timing counts and encodings for the parallel flash bus controller.
  Assumes a 250 MHz system clock; every count derives from a time in ns.
*/
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

`define FBC_CLK_PERIOD_NS 4
// Access time from chip select to valid data, ns
`define FBC_T_CE_NS 70
`define FBC_CE_CYC (((`FBC_T_CE_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Access time from output gate to valid data, ns
`define FBC_T_OE_NS 30
`define FBC_OE_CYC (((`FBC_T_OE_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Write strobe low width, ns
`define FBC_T_WP_NS 35
`define FBC_WP_CYC (((`FBC_T_WP_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Write strobe high recovery, ns
`define FBC_T_WPH_NS 30
`define FBC_WPH_CYC (((`FBC_T_WPH_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Reset pin low pulse width, ns
`define FBC_T_RP_NS 500
`define FBC_RP_CYC (((`FBC_T_RP_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Recovery after reset pin release before a read, ns
`define FBC_T_RH_NS 50
`define FBC_RH_CYC (((`FBC_T_RH_NS) + (`FBC_CLK_PERIOD_NS) - 1) / (`FBC_CLK_PERIOD_NS))
// Timer width
`define FBC_TMR_W 8
// Number of address lines A20..A0
`define FBC_ADDR_W 21
`define FBC_DATA_W 16
// Boost pin level codes
`define FBC_BOOST_LOW 2'h0
`define FBC_BOOST_HIGH 2'h1
`define FBC_BOOST_ELEV 2'h2

`endif

// [fbc_pkg.sv]
/*
  Types for the parallel flash bus controller.
  Assumes fbc_params.svh is on the include path.
*/
`include "fbc_params.svh"

package fbc_pkg;

  typedef enum logic [1:0] {
    FBC_OP_READ = 2'h0,
    FBC_OP_WRITE = 2'h1,
    FBC_OP_RESET = 2'h2
  } fbc_op_type;

  // One request from the user side
  typedef struct packed {
    fbc_op_type op;
    logic byte_mode;
    logic [`FBC_ADDR_W:0] addr;   // Bit 0 is the byte lane bit in byte width
    logic [`FBC_DATA_W-1:0] wdata;
  } fbc_req_type;

  // Levels driven to the device control pins
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic wr_strobe_n;
    logic reset_n;
    logic width_word;
  } fbc_ctl_type;

  typedef enum logic [2:0] {
    FBC_ST_IDLE = 3'h0,
    FBC_ST_RD_WAIT = 3'h1,
    FBC_ST_WR_LOW = 3'h2,
    FBC_ST_WR_HIGH = 3'h3,
    FBC_ST_RST_LOW = 3'h4,
    FBC_ST_RST_REC = 3'h5
  } fbc_state_type;

endpackage : fbc_pkg

// [fbc_timer.sv]
/*
  Down counter giving the controller its pin timing intervals.
  Assumes load and the count come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module fbc_timer
  import fbc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [`FBC_TMR_W-1:0] count,
  output logic done
);

  logic [`FBC_TMR_W-1:0] cnt_r;
  logic [`FBC_TMR_W-1:0] cnt_nxt;

  // Load wins over counting so a new interval starts cleanly
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done ignores load: the sequencer loads on done, so a load term would loop back
  assign done = (cnt_r == '0);

endmodule : fbc_timer

`default_nettype wire

// [fbc_ctrl.sv]
/*
  Host-side controller for an asynchronous parallel flash: turns user
  read, write and reset requests into chip select, output gate, write
  strobe, reset and data pin sequences, and drives the boost pin level.
  Assumes the flash pins are outside the clock domain and a pad ring
  resolves the data pins from the enable.
*/
// How it works
// [RULE1] Elevated boost level selects accelerated programming
// [RULE2] Word width drives A20..A0, byte adds lane
// [RULE3] Boost low keeps outer boot sectors protected
// [RULE4] Width select high uses all sixteen lines
// [RULE5] Byte width: top line carries lane bit
// [RULE6] Reads: select, gate low, strobe high
// [RULE7] After reset, reads return array data directly
// [RULE8] Array data until a command write
// [RULE9] Writes: strobe, select low, gate high
// [RULE10] Program data width follows width select
// [RULE11] Fast program takes two write cycles
// [RULE12] Erase by sector, several, or whole device
// [RULE13] Identification codes read on low eight lines
// [RULE14] Busy status read on low eight lines
// [RULE15] Elevated level enters fast program, unprotects all
// [RULE16] Boost pin elevated only for fast program
// [RULE17] Standby keeps outputs off whatever gate does
// [RULE18] Read after standby waits full select access
// [RULE19] Deselect during busy lets operation finish
// [RULE20] Gate high turns device outputs off
// [RULE21] Reset pulse aborts, tri-states, returns to array
`timescale 1ns/1ps
`default_nettype none

module fbc_ctrl
  import fbc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire fbc_req_type req,
  input wire logic boost_req,
  input wire logic boost_fast_prog,
  output logic rsp_valid,
  output logic [`FBC_DATA_W-1:0] rsp_data,
  output logic [`FBC_ADDR_W-1:0] addr_pins,
  output fbc_ctl_type ctl_pins,
  output logic [1:0] protect_boost_pin,
  input wire logic [`FBC_DATA_W-1:0] data_in,
  output logic [`FBC_DATA_W-1:0] data_out,
  output logic [`FBC_DATA_W-1:0] data_oe
);

  localparam logic [`FBC_TMR_W-1:0] CE_CYC = `FBC_TMR_W'(`FBC_CE_CYC);
  localparam logic [`FBC_TMR_W-1:0] WP_CYC = `FBC_TMR_W'(`FBC_WP_CYC);
  localparam logic [`FBC_TMR_W-1:0] WPH_CYC = `FBC_TMR_W'(`FBC_WPH_CYC);
  localparam logic [`FBC_TMR_W-1:0] RP_CYC = `FBC_TMR_W'(`FBC_RP_CYC);
  localparam logic [`FBC_TMR_W-1:0] RH_CYC = `FBC_TMR_W'(`FBC_RH_CYC);

  fbc_state_type state_r, state_nxt;
  fbc_req_type cur_r, cur_nxt;
  fbc_ctl_type ctl_r, ctl_nxt;
  logic [`FBC_ADDR_W-1:0] addr_r, addr_nxt;
  logic [`FBC_DATA_W-1:0] dout_r, dout_nxt;
  logic [`FBC_DATA_W-1:0] doe_r, doe_nxt;
  logic [`FBC_DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] boost_r, boost_nxt;
  logic [`FBC_DATA_W-1:0] din_meta_r, din_sync_r;
  logic tmr_load;
  logic [`FBC_TMR_W-1:0] tmr_count;
  logic tmr_done;

  fbc_timer u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Data pins come from another timing domain; two flops before use
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= data_in;
      din_sync_r <= din_meta_r;
    end
  end

  // Boost level: elevated only when asked for fast program, never floating
  always_comb begin
    boost_nxt = `FBC_BOOST_LOW; // [RULE3]
    if (boost_req && boost_fast_prog) begin
      boost_nxt = `FBC_BOOST_ELEV; // [RULE1] [RULE15] [RULE16]
    end else if (boost_req) begin
      boost_nxt = `FBC_BOOST_HIGH;
    end
  end

  // Request sequencer; one access at a time keeps strobes mutually exclusive
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    ctl_nxt = ctl_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_r)
      FBC_ST_IDLE: begin
        // Standby between accesses: select high, data released
        ctl_nxt.chip_sel_n = 1'b1; // [RULE17] [RULE19]
        ctl_nxt.out_gate_n = 1'b1;
        ctl_nxt.wr_strobe_n = 1'b1;
        doe_nxt = '0;
        if (req_valid) begin
          cur_nxt = req;
          ctl_nxt.width_word = !req.byte_mode; // [RULE4] [RULE10]
          addr_nxt = req.addr[`FBC_ADDR_W:1]; // [RULE2]
          tmr_load = 1'b1;
          case (req.op)
            FBC_OP_READ: begin
              ctl_nxt.chip_sel_n = 1'b0; // [RULE6]
              ctl_nxt.out_gate_n = 1'b0;
              tmr_count = CE_CYC; // [RULE18]
              if (req.byte_mode) begin
                dout_nxt = {req.addr[0], 15'h0000}; // [RULE5]
                doe_nxt = 16'h8000;
              end
              state_nxt = FBC_ST_RD_WAIT;
            end
            FBC_OP_WRITE: begin
              ctl_nxt.chip_sel_n = 1'b0; // [RULE9]
              ctl_nxt.wr_strobe_n = 1'b0;
              tmr_count = WP_CYC; // [RULE11] [RULE12]
              if (req.byte_mode) begin
                dout_nxt = {req.addr[0], 7'h00, req.wdata[7:0]}; // [RULE5] [RULE10]
                doe_nxt = 16'h80FF;
              end else begin
                dout_nxt = req.wdata;
                doe_nxt = 16'hFFFF;
              end
              state_nxt = FBC_ST_WR_LOW;
            end
            FBC_OP_RESET: begin
              ctl_nxt.reset_n = 1'b0; // [RULE21]
              tmr_count = RP_CYC;
              state_nxt = FBC_ST_RST_LOW;
            end
            default: begin
              tmr_load = 1'b0;
              state_nxt = FBC_ST_IDLE;
            end
          endcase
        end
      end
      FBC_ST_RD_WAIT: begin
        if (tmr_done) begin
          // Array, identification or status data alike; low byte only in byte width
          if (cur_r.byte_mode) begin
            rdata_nxt = {8'h00, din_sync_r[7:0]}; // [RULE13] [RULE14]
          end else begin
            rdata_nxt = din_sync_r; // [RULE8]
          end
          rvalid_nxt = 1'b1;
          ctl_nxt.chip_sel_n = 1'b1;
          ctl_nxt.out_gate_n = 1'b1; // [RULE20]
          doe_nxt = '0;
          state_nxt = FBC_ST_IDLE;
        end
      end
      FBC_ST_WR_LOW: begin
        if (tmr_done) begin
          ctl_nxt.wr_strobe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = WPH_CYC;
          state_nxt = FBC_ST_WR_HIGH;
        end
      end
      FBC_ST_WR_HIGH: begin
        if (tmr_done) begin
          ctl_nxt.chip_sel_n = 1'b1;
          doe_nxt = '0;
          rvalid_nxt = 1'b1;
          state_nxt = FBC_ST_IDLE;
        end
      end
      FBC_ST_RST_LOW: begin
        if (tmr_done) begin
          ctl_nxt.reset_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = RH_CYC; // [RULE7]
          state_nxt = FBC_ST_RST_REC;
        end
      end
      FBC_ST_RST_REC: begin
        if (tmr_done) begin
          rvalid_nxt = 1'b1;
          state_nxt = FBC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = FBC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= FBC_ST_IDLE;
      cur_r <= '0;
      ctl_r <= 5'h1F;
      addr_r <= '0;
      dout_r <= '0;
      doe_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      boost_r <= `FBC_BOOST_LOW;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      ctl_r <= ctl_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      boost_r <= boost_nxt;
    end
  end

  assign req_ready = (state_r == FBC_ST_IDLE);
  assign rsp_valid = rvalid_r;
  assign rsp_data = rdata_r;
  assign addr_pins = addr_r;
  assign ctl_pins = ctl_r;
  assign protect_boost_pin = boost_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;

  // Read and write never overlap on the pins
  chk_strobe_exclusive: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
    !(!ctl_pins.out_gate_n && !ctl_pins.wr_strobe_n))
    else $error("gate and strobe low together");

  chk_read_gate: assert property (@(posedge clock) disable iff (sys_rst) // [RULE20]
    !ctl_pins.out_gate_n |-> (data_oe[14:0] == 15'h0000 && ctl_pins.wr_strobe_n))
    else $error("host drives data while gate low");

  sequence s_read_start;
    state_r == FBC_ST_IDLE && req_valid && req.op == FBC_OP_READ;
  endsequence

  chk_read_access: assert property (@(posedge clock) disable iff (sys_rst) // [RULE18]
    s_read_start |=> !ctl_pins.chip_sel_n [*8])
    else $error("read ended before access time");

  chk_read_answer: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
    s_read_start |-> ##[18:22] rsp_valid)
    else $error("read answer late");

  chk_write_pins: assert property (@(posedge clock) disable iff (sys_rst) // [RULE9]
    !ctl_pins.wr_strobe_n |-> (!ctl_pins.chip_sel_n && ctl_pins.out_gate_n))
    else $error("write without select or with gate low");

  chk_byte_lines: assert property (@(posedge clock) disable iff (sys_rst) // [RULE5]
    (!ctl_pins.width_word && !ctl_pins.chip_sel_n) |-> data_oe[14:8] == 7'h00)
    else $error("middle lines driven in byte width");

  chk_word_lines: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
    (ctl_pins.width_word && !ctl_pins.wr_strobe_n) |-> data_oe == 16'hFFFF)
    else $error("word write not on all lines");

  chk_reset_pulse: assert property (@(posedge clock) disable iff (sys_rst) // [RULE21]
    $fell(ctl_pins.reset_n) |-> (!ctl_pins.reset_n && ctl_pins.chip_sel_n) [*8])
    else $error("reset pulse too short");

  chk_boost_elev: assert property (@(posedge clock) disable iff (sys_rst) // [RULE16]
    protect_boost_pin == `FBC_BOOST_ELEV |-> $past(boost_fast_prog))
    else $error("elevated level without fast program");

endmodule : fbc_ctrl

`default_nettype wire

// [fbc_flash_model.sv]
/*
  Behavioural parallel flash device facing fbc_ctrl.
  Assumes the pins come straight from fbc_ctrl and word 0 is a boot sector.
*/
`timescale 1ns/1ps
`default_nettype none

module fbc_flash_model
  import fbc_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identification value
)
(
  input wire logic clock,
  input wire logic [20:0] addr_pins,
  input wire fbc_ctl_type ctl_pins,
  input wire logic [1:0] protect_boost_pin,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  output logic [15:0] wire_data
);
  logic [15:0] mem [0:15];
  logic [15:0] flt = 16'h5A5A;
  logic id_mode = 1'b0;
  logic [15:0] word;
  logic [15:0] val;
  logic [15:0] en;

  // Known array contents so reads need no command first
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);

  // Released lines float to a pattern that changes every cycle
  always @(posedge clock) flt <= ~flt;

  // Commands and program data land on the strobe's rising edge
  always @(posedge ctl_pins.wr_strobe_n or negedge ctl_pins.reset_n) begin
    if (!ctl_pins.reset_n) id_mode <= 1'b0;
    else if (!ctl_pins.chip_sel_n && ctl_pins.out_gate_n) begin
      if (addr_pins == 21'h555 && data_out == 16'h0090) id_mode <= 1'b1;
      else if (data_out == 16'h00F0) id_mode <= 1'b0;
      // Boot word stays protected unless the pin is elevated
      else if (addr_pins[3:0] != 4'h0 || protect_boost_pin == `FBC_BOOST_ELEV)
        mem[addr_pins[3:0]] <= data_out;
    end
  end

  // Device drives only while selected, gated on and out of reset
  always_comb begin
    word = mem[addr_pins[3:0]];
    val = ctl_pins.width_word ? word : {8'h00, data_out[15] ? word[15:8] : word[7:0]};
    if (id_mode) val = {8'h00, ID_CODE};
    en = 16'h0000;
    if (!ctl_pins.chip_sel_n && !ctl_pins.out_gate_n && ctl_pins.reset_n) begin
      en = ctl_pins.width_word ? 16'hFFFF : 16'h00FF;
    end
    wire_data = (data_oe & data_out) | (~data_oe & en & val) | (~data_oe & ~en & flt);
  end
endmodule : fbc_flash_model

`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for fbc_ctrl against the behavioural flash model.
  Assumes fbc_pkg and fbc_flash_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import fbc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic boost_req = 1'b0;
  logic boost_fast_prog = 1'b0;
  fbc_req_type req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_data, data_in, data_out, data_oe, snap_oe, snap_do;
  logic [20:0] addr_pins, snap_a;
  fbc_ctl_type ctl_pins, snap_ctl;
  logic [1:0] protect_boost_pin;
  int num_errors = 0;
  int n_tests = 0;

  always #2 clock = ~clock;

  fbc_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .boost_req(boost_req),
    .boost_fast_prog(boost_fast_prog), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .addr_pins(addr_pins), .ctl_pins(ctl_pins), .protect_boost_pin(protect_boost_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  fbc_flash_model flash_u (.clock(clock), .addr_pins(addr_pins), .ctl_pins(ctl_pins),
    .protect_boost_pin(protect_boost_pin), .data_out(data_out), .data_oe(data_oe),
    .wire_data(data_in));

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One request: wait to be taken, snapshot the pins early, wait for the answer
  task automatic do_op(input fbc_op_type op, input logic bm, input logic [21:0] a,
    input logic [15:0] wd);
    int i;
    req <= '{op, bm, a, wd};
    req_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    req_valid <= 1'b0;
    if (i >= 50) begin
      num_errors++;
      close_out();
    end
    repeat (3) @(posedge clock);
    snap_ctl = ctl_pins;
    snap_oe = data_oe;
    snap_do = data_out;
    snap_a = addr_pins;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rsp_valid !== 1'b1 && i < 300);
    if (i >= 300) begin
      num_errors++;
      close_out();
    end
  endtask : do_op

  // Pins rest deselected and out of reset once sys_rst drops
  task automatic t_reset_vals();
    chk("ctl_pins", 22'h1F, 22'(ctl_pins));
    chk("data_oe", 22'h0, 22'(data_oe));
    chk("ready rsp", 22'h2, 22'({req_ready, rsp_valid}));
  endtask : t_reset_vals

  // Word read, word program, back-to-back read of the new value
  task automatic t_word();
    do_op(FBC_OP_READ, 1'b0, {21'd2, 1'b0}, 16'h0);
    chk("read word", 22'h1002, 22'(rsp_data));
    chk("read pins", 22'h1, 22'(snap_ctl[4:2]));
    chk("read oe", 22'h0, 22'(snap_oe));
    chk("width", 22'h1, 22'(snap_ctl.width_word));
    do_op(FBC_OP_WRITE, 1'b0, {21'd5, 1'b0}, 16'hBEEF);
    chk("write pins", 22'h2, 22'(snap_ctl[4:2]));
    chk("write data", 22'hBEEF, 22'(snap_oe & snap_do));
    chk("write addr", 22'h5, 22'(snap_a));
    do_op(FBC_OP_READ, 1'b0, {21'd5, 1'b0}, 16'h0);
    chk("read back", 22'hBEEF, 22'(rsp_data));
  endtask : t_word

  // Byte width: lane bit rides on the top data line
  task automatic t_byte();
    do_op(FBC_OP_READ, 1'b1, {21'd5, 1'b1}, 16'h0);
    chk("byte hi", 22'h00BE, 22'(rsp_data));
    chk("byte oe", 22'h8000, 22'(snap_oe));
    chk("byte lane", 22'h8000, 22'(snap_do & 16'h8000));
    chk("byte width", 22'h0, 22'(snap_ctl.width_word));
    do_op(FBC_OP_READ, 1'b1, {21'd5, 1'b0}, 16'h0);
    chk("byte lo", 22'h00EF, 22'(rsp_data));
  endtask : t_byte

  // Boost level codes, and boot word programming only at the elevated level
  task automatic set_boost(input logic r, input logic f, input logic [1:0] exp);
    boost_req <= r;
    boost_fast_prog <= f;
    repeat (3) @(posedge clock);
    chk("boost level", 22'(exp), 22'(protect_boost_pin));
  endtask : set_boost

  task automatic t_boost();
    set_boost(1'b1, 1'b0, `FBC_BOOST_HIGH);
    do_op(FBC_OP_WRITE, 1'b0, 22'h0, 16'h1234);
    do_op(FBC_OP_READ, 1'b0, 22'h0, 16'h0);
    chk("boot kept", 22'h1000, 22'(rsp_data));
    set_boost(1'b1, 1'b1, `FBC_BOOST_ELEV);
    do_op(FBC_OP_WRITE, 1'b0, 22'h0, 16'h1234);
    // Elevated level is for programming only, so it drops before the read back
    set_boost(1'b0, 1'b0, `FBC_BOOST_LOW);
    do_op(FBC_OP_READ, 1'b0, 22'h0, 16'h0);
    chk("boot prog", 22'h1234, 22'(rsp_data));
  endtask : t_boost

  // Identification read, then a reset pulse back to array data
  task automatic t_ident();
    do_op(FBC_OP_WRITE, 1'b0, {21'h555, 1'b0}, 16'h0090);
    do_op(FBC_OP_READ, 1'b0, {21'd3, 1'b0}, 16'h0);
    chk("ident", 22'h5A, 22'(rsp_data[7:0]));
    do_op(FBC_OP_RESET, 1'b0, 22'h0, 16'h0);
    chk("reset pin", 22'h0, 22'(snap_ctl.reset_n));
    do_op(FBC_OP_READ, 1'b0, {21'd2, 1'b0}, 16'h0);
    chk("after reset", 22'h1002, 22'(rsp_data));
  endtask : t_ident

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset_vals();
    t_word();
    t_byte();
    t_boost();
    t_ident();
    close_out();
  end
endmodule : testbench

`default_nettype wire
